// ### verilog/sar_pkg.sv
// Function
// [R1] Sticky sync alarm flag, bit 7, sets when the selected monitor reaches alarm.
// [R2] Flag reads 0 with no alarm, 1 after one; writing 1 clears it.
// [R3] Upper interrupt byte maps status bits 23:16 and resets to 0001 0000.
// [R4] Operating-state bit 7 shows the live, unlatched sync monitor alarm.
// [R5] Operating-state byte is read-only, shows machine state, resets to 0000 0001.
// [R6] Upper interrupt bits 6:0 are unused; writing them changes nothing.
package sar_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [6:0] SAR_OFS_INT_UPPER = 7'h08;
  localparam logic [6:0] SAR_OFS_OP_STATE  = 7'h09;
  localparam logic [7:0] SAR_RST_INT_UPPER = 8'h10;
  localparam logic [7:0] SAR_RST_OP_STATE  = 8'h01;
  localparam logic [7:0] SAR_RD_UNMAPPED   = 8'h00;
  localparam int         SAR_BIT_SYNC      = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame layout: command byte {read, addr[6:0]}, then one data byte
  localparam int         SAR_BIT_RD        = 7;
  localparam logic [2:0] SAR_LAST_BIT      = 3'h7;
  localparam int         SAR_SYNC_STAGES   = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } sar_spi_pins_t;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_ADDR,
    SAR_DATA,
    SAR_HOLD
  } sar_state_t;

endpackage

// ### verilog/sar_sync2.sv
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pin levels
module sar_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // First stage feeds only the second
  always_comb begin
    nxt_meta = d;
    nxt_q    = meta_ff;
  end

  // Register both stages; idle level is all ones (chip select released)
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '1;
      q_ff    <= '1;
    end else begin
      meta_ff <= nxt_meta;
      q_ff    <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule

// ### verilog/sar_status_regs.sv
`timescale 1ns/1ps
// Sync alarm status registers behind a mode-0 serial configuration port
module sar_status_regs (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  // Serial configuration port pins
  input  wire sar_pkg::sar_spi_pins_t spi_pins,
  output logic                        miso,
  output logic                        miso_oe_n,
  // Device-internal status sources
  input  wire logic                   sync_alarm_live,
  input  wire logic [6:0]             op_state_low,
  // Register contents
  output logic [7:0]                  int_upper,
  output logic [7:0]                  op_state
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  sar_pkg::sar_spi_pins_t pins_s;

  sar_sync2 #(
    .W ($bits(sar_pkg::sar_spi_pins_t))
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       (spi_pins),
    .q       (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                sclk_d_ff;
  logic                nxt_sclk_d;
  logic                sclk_rise;
  logic                sclk_fall;
  sar_pkg::sar_state_t state_ff;
  sar_pkg::sar_state_t nxt_state;
  logic [2:0]          cnt_ff;
  logic [2:0]          nxt_cnt;
  logic [7:0]          sh_ff;
  logic [7:0]          nxt_sh;
  logic [7:0]          cmd_ff;
  logic [7:0]          nxt_cmd;
  logic [7:0]          rd_sh_ff;
  logic [7:0]          nxt_rd_sh;
  logic                miso_ff;
  logic                nxt_miso;
  logic                miso_oe_n_ff;
  logic                nxt_miso_oe_n;
  logic                clr_req;
  logic [7:0]          shifted;
  logic                alarm_d_ff;
  logic                nxt_alarm_d;
  logic                flag_ff;
  logic                nxt_flag;
  logic [7:0]          op_state_ff;
  logic [7:0]          nxt_op_state;
  logic [7:0]          int_upper_ff;
  logic [7:0]          nxt_int_upper;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux

  function automatic logic [7:0] rd_mux(input logic [6:0] addr,
                                        input logic [7:0] int_val,
                                        input logic [7:0] op_val);
    logic [7:0] r;
    r = sar_pkg::SAR_RD_UNMAPPED;
    if (addr == sar_pkg::SAR_OFS_INT_UPPER) begin
      r = int_val;
    end else if (addr == sar_pkg::SAR_OFS_OP_STATE) begin
      r = op_val;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock edge detection

  always_comb begin
    nxt_sclk_d = pins_s.sclk;
  end

  assign sclk_rise = pins_s.sclk & ~sclk_d_ff;
  assign sclk_fall = ~pins_s.sclk & sclk_d_ff;
  assign shifted   = {sh_ff[6:0], pins_s.mosi};

  // Delayed clock resets to the synchroniser's reset level, so no false rising edge follows reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= nxt_sclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame state machine: command byte, then one data byte

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_sh        = sh_ff;
    nxt_cmd       = cmd_ff;
    nxt_rd_sh     = rd_sh_ff;
    nxt_miso      = miso_ff;
    clr_req       = 1'b0;
    if (pins_s.cs_n) begin
      nxt_state = sar_pkg::SAR_IDLE;
      nxt_cnt   = 3'h0;
    end else begin
      case (state_ff)
        sar_pkg::SAR_IDLE: begin
          nxt_state = sar_pkg::SAR_ADDR;
          nxt_cnt   = 3'h0;
        end
        sar_pkg::SAR_ADDR: begin
          if (sclk_rise) begin
            nxt_sh  = shifted;
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == sar_pkg::SAR_LAST_BIT) begin
              nxt_cmd   = shifted;
              nxt_state = sar_pkg::SAR_DATA;
              nxt_rd_sh = rd_mux(shifted[6:0], int_upper_ff, op_state_ff);
            end
          end
        end
        sar_pkg::SAR_DATA: begin
          if (sclk_rise) begin
            nxt_sh  = shifted;
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == sar_pkg::SAR_LAST_BIT) begin
              nxt_state = sar_pkg::SAR_HOLD;
              // Only bit 7 acts; other bits and the read-only byte ignore writes
              if (!cmd_ff[sar_pkg::SAR_BIT_RD] && cmd_ff[6:0] == sar_pkg::SAR_OFS_INT_UPPER) begin
                clr_req = shifted[sar_pkg::SAR_BIT_SYNC]; // see [R2] see [R6] see [R5]
              end
            end
          end
          if (sclk_fall && cmd_ff[sar_pkg::SAR_BIT_RD]) begin
            nxt_miso  = rd_sh_ff[7];
            nxt_rd_sh = {rd_sh_ff[6:0], 1'b0};
          end
        end
        sar_pkg::SAR_HOLD: begin
          nxt_state = sar_pkg::SAR_HOLD;
        end
        default: begin
          nxt_state = sar_pkg::SAR_IDLE;
        end
      endcase
    end
    // Drive the data line from the data byte of a read until chip select is released
    nxt_miso_oe_n = ~((nxt_state == sar_pkg::SAR_DATA || nxt_state == sar_pkg::SAR_HOLD)
                      && nxt_cmd[sar_pkg::SAR_BIT_RD]);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff     <= sar_pkg::SAR_IDLE;
      cnt_ff       <= 3'h0;
      sh_ff        <= 8'h00;
      cmd_ff       <= 8'h00;
      rd_sh_ff     <= 8'h00;
      miso_ff      <= 1'b0;
      miso_oe_n_ff <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      sh_ff        <= nxt_sh;
      cmd_ff       <= nxt_cmd;
      rd_sh_ff     <= nxt_rd_sh;
      miso_ff      <= nxt_miso;
      miso_oe_n_ff <= nxt_miso_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky sync alarm flag and upper interrupt byte

  always_comb begin
    nxt_alarm_d = sync_alarm_live;
    // Onset of alarm sets; a set in the clearing cycle wins
    nxt_flag    = (sync_alarm_live & ~alarm_d_ff) | (flag_ff & ~clr_req); // see [R1] see [R2]
    // Bits 6:0 hold their reset pattern for good
    nxt_int_upper = {nxt_flag, sar_pkg::SAR_RST_INT_UPPER[6:0]}; // see [R3] see [R6]
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_d_ff   <= 1'b0;
      flag_ff      <= sar_pkg::SAR_RST_INT_UPPER[sar_pkg::SAR_BIT_SYNC];
      int_upper_ff <= sar_pkg::SAR_RST_INT_UPPER; // see [R3]
    end else begin
      alarm_d_ff   <= nxt_alarm_d;
      flag_ff      <= nxt_flag;
      int_upper_ff <= nxt_int_upper;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operating-state byte: live alarm plus state machine bits

  always_comb begin
    nxt_op_state = {sync_alarm_live, op_state_low}; // see [R4] see [R5]
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_state_ff <= sar_pkg::SAR_RST_OP_STATE; // see [R5]
    end else begin
      op_state_ff <= nxt_op_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign miso      = miso_ff;
  assign miso_oe_n = miso_oe_n_ff;
  assign int_upper = int_upper_ff;
  assign op_state  = op_state_ff;

endmodule

// ### tb/sar_status_assertions.sv
`timescale 1ns/1ps
// Port checks on the sync alarm status registers
module sar_status_assertions (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  // Watched ports
  input wire sar_pkg::sar_spi_pins_t spi_pins,
  input wire logic                   miso_oe_n,
  input wire logic                   sync_alarm_live,
  input wire logic [6:0]             op_state_low,
  input wire logic [7:0]             int_upper,
  input wire logic [7:0]             op_state
);
  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flag, fixed bits and live state
  a_flag_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(sync_alarm_live) |=> int_upper[7]) else $error("flag missed alarm onset");
  a_flag_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(int_upper[7]) |-> $past(sync_alarm_live)) else $error("flag set without alarm");
  a_fixed_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    int_upper[6:0] == 7'h10) else $error("unused interrupt bits moved");
  a_state_follows: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> op_state[7] == $past(sync_alarm_live) && op_state[6:0] == $past(op_state_low))
    else $error("operating state does not follow sources");
  a_reset_vals: assert property (@(posedge ref_clk)
    sys_rst |-> int_upper == 8'h10 && op_state == 8'h01) else $error("wrong reset values");
  a_idle_oe: assert property (@(posedge ref_clk) disable iff (sys_rst)
    spi_pins.cs_n [*4] |-> miso_oe_n) else $error("read data driven outside a frame");
endmodule

bind sar_status_regs sar_status_assertions chk_u (
  .ref_clk         (ref_clk),
  .sys_rst         (sys_rst),
  .spi_pins        (spi_pins),
  .miso_oe_n       (miso_oe_n),
  .sync_alarm_live (sync_alarm_live),
  .op_state_low    (op_state_low),
  .int_upper       (int_upper),
  .op_state        (op_state)
);

// ### tb/sar_host_model.sv
`timescale 1ns/1ps
// Host software side of the serial configuration port
module sar_host_model (
  // Clock
  input  wire logic             ref_clk,
  // Serial port
  output sar_pkg::sar_spi_pins_t spi_pins,
  input  wire logic             miso
);
  localparam int HALF = 6;
  initial spi_pins = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
  // Waits n edges, then steps just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One frame: command byte then data byte, MSB first, sampled on rises
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {rd, addr, wd}; // Write data of 1 at the flag clears it
    rdat = 8'h00;
    spi_pins.cs_n = 1'b0;
    tick(HALF);
    for (int i = 15; i >= 0; i--) begin
      spi_pins.mosi = sh[i];
      tick(HALF);
      if (i < 8) rdat = {rdat[6:0], miso};
      spi_pins.sclk = 1'b1;
      tick(HALF);
      spi_pins.sclk = 1'b0;
    end
    tick(HALF);
    spi_pins.cs_n = 1'b1;
    spi_pins.mosi = ~spi_pins.mosi; // No stale data once deselected
    tick(HALF);
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the sync alarm status registers
module tb_top;
  logic                   ref_clk;
  logic                   sys_rst;
  logic                   sync_alarm_live;
  logic [6:0]             op_state_low;
  sar_pkg::sar_spi_pins_t spi_pins;
  logic                   miso;
  logic                   miso_line;
  logic                   miso_oe_n;
  logic [7:0]             int_upper;
  logic [7:0]             op_state;
  logic [7:0]             rd;
  int                     n_errors;
  int                     samples_checked;
  int                     cycles;

  sar_status_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .spi_pins(spi_pins), .miso(miso),
    .miso_oe_n(miso_oe_n), .sync_alarm_live(sync_alarm_live), .op_state_low(op_state_low),
    .int_upper(int_upper), .op_state(op_state));
  // Released data line shows the inverse of its last value, so stale reads show up
  assign miso_line = miso_oe_n ? ~miso : miso;
  sar_host_model host_u (.ref_clk(ref_clk), .spi_pins(spi_pins), .miso(miso_line));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and closing tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    host_u.xfer(1'b1, a, 8'h00, rd);
    chk("serial read", exp, rd);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, rd);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    sys_rst = 1'b1;
    sync_alarm_live = 1'b0;
    op_state_low = 7'h01;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("int_upper port", 8'h10, int_upper);
    chk("op_state port", 8'h01, op_state);
    rd_chk(7'h08, 8'h10);
    rd_chk(7'h09, 8'h01);
    $display("test reset values done");
    op_state_low = 7'h2a;
    sync_alarm_live = 1'b1;
    rd_chk(7'h09, 8'haa);
    rd_chk(7'h08, 8'h90);
    sync_alarm_live = 1'b0;
    rd_chk(7'h09, 8'h2a);
    rd_chk(7'h08, 8'h90);
    $display("test alarm done");
    wr(7'h08, 8'h7f);
    rd_chk(7'h08, 8'h90);
    wr(7'h08, 8'h80);
    rd_chk(7'h08, 8'h10);
    wr(7'h09, 8'hff);
    rd_chk(7'h09, 8'h2a);
    rd_chk(7'h20, 8'h00);
    $display("test writes done");
    // A fresh onset sets again; clearing under a standing alarm leaves the flag at 0
    sync_alarm_live = 1'b1;
    rd_chk(7'h08, 8'h90);
    wr(7'h08, 8'h80);
    rd_chk(7'h08, 8'h10);
    sync_alarm_live = 1'b0;
    $display("test standing alarm done");
    end_sim();
  end
endmodule
